/* include/ssdc_pkg.sv */
// shared constants, types and carriers of the synchronous sram data and output control block
package ssdc_pkg;

    // ******************************************************************
    // geometry
    // ******************************************************************
    localparam int LANES = 8;
    localparam int BYTE_W = 8;
    localparam int DATA_W = LANES * BYTE_W;
    localparam int ADDR_W = 6;
    localparam int BURST_W = 2;
    localparam int FIFO_DEPTH = 8;

    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic RST_DRIVE = 1'b0;
    localparam logic RST_EMERGE = 1'b0;
    localparam logic [BURST_W-1:0] RST_COUNT = 2'h0;
    localparam logic [ADDR_W-1:0] RST_BASE = 6'h00;
    localparam logic RST_SYNC = 1'b1;

    // ******************************************************************
    // types
    // ******************************************************************
    typedef enum logic [1:0] {OP_DESEL, OP_READ, OP_WRITE} ssdc_op_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] parity;
        logic [LANES-1:0] laneEnN;
    } ssdc_wr_s;

endpackage : ssdc_pkg

/* verilog/ssdc_fifo.sv */
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module ssdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [PW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [PW:0] count_r, count_nxt;
    logic push, pop;

    assign inReady = (count_r < (PW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = store_r[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (push) begin
            wrPtr_nxt = (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
        end
        if (pop) begin
            rdPtr_nxt = (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
        end
        case ({push, pop})
            2'b10: count_nxt = count_r + 1'b1;
            2'b01: count_nxt = count_r - 1'b1;
            default: count_nxt = count_r;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    // storage has no reset: contents are never read while empty
    always_ff @(posedge ref_clk) begin
        if (push) begin
            store_r[wrPtr_r] <= inData;
        end
    end

endmodule : ssdc_fifo

/* verilog/ssdc_sram_io.sv */
// data path, burst order and output drive control of the pipelined sram
`timescale 1ns/1ps
module ssdc_sram_io
    import ssdc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // synchronous control pins
    input wire logic clockQualifierN,
    input wire logic chipSelectOneN,
    input wire logic chipSelectTwo,
    input wire logic chipSelectThreeN,
    input wire logic writeEnableN,
    input wire logic advanceOrLoad,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [LANES-1:0] byteWriteSelectN,
    // asynchronous pins
    input wire logic outputEnableN,
    input wire logic burstOrderStrap,
    input wire logic burstOrderDriven,
    // data pins
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    // parity pins
    input wire logic [LANES-1:0] parityIn,
    output logic [LANES-1:0] parityOut,
    output logic parityOe,
    // status
    output logic writeBufReady
);

    // ******************************************************************
    // pin synchronisers for the asynchronous inputs
    // ******************************************************************
    logic oeMeta_r, oeSync_r, modeMeta_r, modeSync_r;
    logic modeRaw;

    assign modeRaw = burstOrderStrap | ~burstOrderDriven;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            oeMeta_r <= RST_SYNC;
            oeSync_r <= RST_SYNC;
            modeMeta_r <= RST_SYNC;
            modeSync_r <= RST_SYNC;
        end else begin
            oeMeta_r <= outputEnableN;
            oeSync_r <= oeMeta_r;
            modeMeta_r <= modeRaw;
            modeSync_r <= modeMeta_r;
        end
    end

    // ******************************************************************
    // command stage and burst counter
    // ******************************************************************
    ssdc_op_e op_r, op_nxt;
    logic [ADDR_W-1:0] base_r, base_nxt, curAddr;
    logic [BURST_W-1:0] cnt_r, cnt_nxt, lowBits;
    logic qualified, selected;

    assign qualified = ~clockQualifierN;
    assign selected = ~chipSelectOneN & chipSelectTwo & ~chipSelectThreeN;

    // only the two low bits walk; the rest of the start address is held
    assign lowBits = modeSync_r ? (base_r[BURST_W-1:0] ^ cnt_r)
                                : (base_r[BURST_W-1:0] + cnt_r);
    assign curAddr = {base_r[ADDR_W-1:BURST_W], lowBits};

    always_comb begin
        op_nxt = op_r;
        base_nxt = base_r;
        cnt_nxt = cnt_r;
        if (qualified) begin
            if (!advanceOrLoad) begin
                base_nxt = address;
                cnt_nxt = RST_COUNT;
                if (!selected) begin
                    op_nxt = OP_DESEL;
                end else if (writeEnableN) begin
                    op_nxt = OP_READ;
                end else begin
                    op_nxt = OP_WRITE;
                end
            end else begin
                // access type is kept through the burst; 2-bit count wraps
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_r <= OP_DESEL;
            base_r <= RST_BASE;
            cnt_r <= RST_COUNT;
        end else begin
            op_r <= op_nxt;
            base_r <= base_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ******************************************************************
    // write data capture through the buffer into the array
    // ******************************************************************
    ssdc_wr_s wrWord, drainWord;
    logic wrPush, drainValid, drainWrite;
    logic [DATA_W-1:0] memData_r [2**ADDR_W];
    logic [LANES-1:0] memPar_r [2**ADDR_W];

    assign wrWord = '{addr: curAddr, data: dataIn, parity: parityIn,
                      laneEnN: byteWriteSelectN};
    assign wrPush = qualified && (op_r == OP_WRITE);
    // draining stalls with the clock qualifier so the array is frozen too
    assign drainWrite = drainValid && qualified;

    ssdc_fifo #(
        .WIDTH($bits(ssdc_wr_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wrBuf (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .inValid(wrPush),
        .inReady(writeBufReady),
        .inData(wrWord),
        .outValid(drainValid),
        .outReady(qualified),
        .outData(drainWord)
    );

    // one process owns the array; a lane with its select high keeps its old byte
    always_ff @(posedge ref_clk) begin
        for (int lane = 0; lane < LANES; lane++) begin
            if (drainWrite && !drainWord.laneEnN[lane]) begin
                memData_r[drainWord.addr][lane*BYTE_W +: BYTE_W] <=
                    drainWord.data[lane*BYTE_W +: BYTE_W];
                memPar_r[drainWord.addr][lane] <= drainWord.parity[lane];
            end
        end
    end

    // ******************************************************************
    // output register and drive control
    // ******************************************************************
    logic drive_r, drive_nxt, emerge_r, emerge_nxt;
    logic [DATA_W-1:0] dataOut_nxt;
    logic [LANES-1:0] parityOut_nxt;

    always_comb begin
        drive_nxt = drive_r;
        emerge_nxt = emerge_r;
        dataOut_nxt = dataOut;
        parityOut_nxt = parityOut;
        if (qualified) begin
            emerge_nxt = (op_r == OP_DESEL) && (op_nxt != OP_DESEL);
            // a write loaded right after a read owns the pins for its data phase
            drive_nxt = (op_r == OP_READ) && (op_nxt != OP_WRITE);
            if (op_r == OP_READ) begin
                dataOut_nxt = memData_r[curAddr];
                parityOut_nxt = memPar_r[curAddr];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_r <= RST_DRIVE;
            emerge_r <= RST_EMERGE;
            dataOut <= '0;
            parityOut <= '0;
        end else begin
            drive_r <= drive_nxt;
            emerge_r <= emerge_nxt;
            dataOut <= dataOut_nxt;
            parityOut <= parityOut_nxt;
        end
    end

    // output enable is asynchronous on the pin, so it acts two edges late here
    assign dataOe = drive_r & ~emerge_r & ~oeSync_r;
    assign parityOe = dataOe;

    // ******************************************************************
    // assertions
    // ******************************************************************
    logic [DATA_W-1:0] rdData;
    assign rdData = memData_r[curAddr];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    oe_mask_a: assert property (oeSync_r |-> !dataOe)
        else $error("pins driven while output enable is high");
    drive_on_a: assert property (drive_r && !emerge_r && !oeSync_r |-> dataOe)
        else $error("read data not driven");
    write_tri_a: assert property (op_r == OP_WRITE |-> !dataOe)
        else $error("pins driven in write data phase");
    desel_pipe_a: assert property (
        (qualified && !advanceOrLoad && !selected) ##1 qualified |=> !dataOe)
        else $error("deselect did not float pins");
    freeze_a: assert property (clockQualifierN |=>
        $stable(op_r) && $stable(cnt_r) && $stable(base_r))
        else $error("state moved while qualifier high");
    hold_out_a: assert property (clockQualifierN |=> $stable(dataOut) && $stable(drive_r))
        else $error("outputs changed while qualifier high");
    read_lat_a: assert property (qualified && op_r == OP_READ |=> dataOut == $past(rdData))
        else $error("read data not from previous address");
    parity_dir_a: assert property (parityOe == dataOe)
        else $error("parity direction differs from data");
    linear_step_a: assert property (
        qualified && advanceOrLoad && !modeSync_r && $stable(modeSync_r)
        |=> lowBits == $past(lowBits) + 2'h1)
        else $error("linear burst step wrong");
    inter_step_a: assert property (
        qualified && advanceOrLoad && modeSync_r && $stable(modeSync_r)
        |=> lowBits == (base_r[1:0] ^ ($past(cnt_r) + 2'h1)))
        else $error("interleaved burst step wrong");
    strap_float_a: assert property (!burstOrderDriven [*3] |-> modeSync_r)
        else $error("floating strap not read as interleaved");
    capture_a: assert property (wrPush && writeBufReady |=> drainValid)
        else $error("write data not captured");

    read_seen_c: cover property (op_r == OP_READ ##1 dataOe);
    write_seen_c: cover property (wrPush && !byteWriteSelectN[0]);
    wrap_seen_c: cover property (qualified && advanceOrLoad && cnt_r == 2'h3);
    freeze_seen_c: cover property (drive_r && clockQualifierN [*3]);

endmodule : ssdc_sram_io

/* verification/ssdc_host_model.sv */
// behavioural host memory controller driving the sram pins
`timescale 1ns/1ps
module ssdc_host_model
    import ssdc_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // synchronous control pins
    output logic clockQualifierN,
    output logic chipSelectOneN,
    output logic chipSelectTwo,
    output logic chipSelectThreeN,
    output logic writeEnableN,
    output logic advanceOrLoad,
    output logic [ADDR_W-1:0] address,
    output logic [LANES-1:0] byteWriteSelectN,
    // data and parity pins
    output logic [DATA_W-1:0] dataIn,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe,
    output logic [LANES-1:0] parityIn,
    input wire logic [LANES-1:0] parityOut,
    input wire logic parityOe
);
    logic [DATA_W-1:0] hostData;
    logic [LANES-1:0] hostPar;
    logic hostEn;
    logic [1:0] csPick;

    // a released bus shows the inverse of the last value, so a stale copy never matches
    assign dataIn = dataOe ? dataOut : (hostEn ? hostData : ~hostData);
    assign parityIn = parityOe ? parityOut : (hostEn ? hostPar : ~hostPar);

    initial begin
        clockQualifierN = 1'b0;
        {chipSelectOneN, chipSelectTwo, chipSelectThreeN} = 3'h5;
        {writeEnableN, advanceOrLoad, hostEn} = 3'h4;
        {address, byteWriteSelectN} = '1;
        {hostData, hostPar, csPick} = '0;
    end

    // one qualified cycle: pins change at the falling edge, held over the rising edge
    task automatic step(input logic adv, input ssdc_op_e op, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [LANES-1:0] p,
                        input logic [LANES-1:0] bwN, input logic drv);
        @(negedge ref_clk);
        clockQualifierN = 1'b0;
        {chipSelectOneN, chipSelectTwo, chipSelectThreeN} = 3'h2;
        if (op == OP_DESEL && !adv) begin
            // rotate which select drops so each one deselects
            case (csPick)
                2'h0: chipSelectOneN = 1'b1;
                2'h1: chipSelectTwo = 1'b0;
                default: chipSelectThreeN = 1'b1;
            endcase
            csPick = (csPick == 2'h2) ? 2'h0 : csPick + 2'h1;
        end
        {advanceOrLoad, writeEnableN, address} = {adv, op != OP_WRITE, a};
        {hostData, hostPar, byteWriteSelectN, hostEn} = {d, p, bwN, drv};
        @(posedge ref_clk);
    endtask : step

    // a selected write load that must be ignored while the qualifier is high
    task automatic freeze(input int n);
        @(negedge ref_clk);
        {clockQualifierN, writeEnableN, advanceOrLoad} = 3'h4;
        {chipSelectOneN, chipSelectTwo, chipSelectThreeN} = 3'h2;
        address = ~address;
        repeat (n) @(posedge ref_clk);
    endtask : freeze
endmodule : ssdc_host_model

/* verification/tb_top.sv */
// self-checking testbench of the sram data and output control block
`timescale 1ns/1ps
module tb_top
    import ssdc_pkg::*;
;
    logic ref_clk, arst_n, outputEnableN, burstOrderStrap, burstOrderDriven;
    logic clockQualifierN, chipSelectOneN, chipSelectTwo, chipSelectThreeN;
    logic writeEnableN, advanceOrLoad, dataOe, parityOe, writeBufReady;
    logic [ADDR_W-1:0] address;
    logic [LANES-1:0] byteWriteSelectN, parityIn, parityOut;
    logic [DATA_W-1:0] dataIn, dataOut;
    logic [LANES+DATA_W-1:0] expMem [2**ADDR_W];
    int failures, checked;

    ssdc_sram_io ssdc_sram_io_i (.ref_clk, .arst_n, .clockQualifierN, .chipSelectOneN,
        .chipSelectTwo, .chipSelectThreeN, .writeEnableN, .advanceOrLoad, .address,
        .byteWriteSelectN, .outputEnableN, .burstOrderStrap, .burstOrderDriven, .dataIn,
        .dataOut, .dataOe, .parityIn, .parityOut, .parityOe, .writeBufReady);
    ssdc_host_model ssdc_host_model_i (.ref_clk, .clockQualifierN, .chipSelectOneN,
        .chipSelectTwo, .chipSelectThreeN, .writeEnableN, .advanceOrLoad, .address,
        .byteWriteSelectN, .dataIn, .dataOut, .dataOe, .parityIn, .parityOut, .parityOe);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ******************************************************************
    // compare and access tasks
    // ******************************************************************
    task automatic check_word(input string nm, input logic [LANES+DATA_W-1:0] e, g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check_word

    task automatic check_flag(input string nm, input logic e, g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : check_flag

    function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] s, input int i,
                                                input logic il);
        logic [1:0] c;
        c = 2'(i);
        return {s[ADDR_W-1:2], il ? s[1:0] ^ c : s[1:0] + c};
    endfunction : baddr

    task automatic idle(input int n);
        repeat (n) ssdc_host_model_i.step(1'b0, OP_DESEL, '0, '0, '0, '1, 1'b0);
    endtask : idle

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [LANES-1:0] p, bwN);
        ssdc_host_model_i.step(1'b0, OP_WRITE, a, '0, '0, '1, 1'b0);
        ssdc_host_model_i.step(1'b0, OP_DESEL, a, d, p, bwN, 1'b1);
        #1;
        check_flag("write float", 1'b0, dataOe);
        for (int i = 0; i < LANES; i++) begin
            if (!bwN[i]) begin
                expMem[a][8*i +: 8] = d[8*i +: 8];
                expMem[a][DATA_W+i] = p[i];
            end
        end
        idle(1);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic oeExp);
        ssdc_host_model_i.step(1'b0, OP_READ, a, '0, '0, '1, 1'b0);
        ssdc_host_model_i.step(1'b0, OP_DESEL, a, '0, '0, '1, 1'b0);
        #1;
        check_word("read word", expMem[a], {parityOut, dataOut});
        check_flag("read drive", oeExp, dataOe);
        check_flag("parity drive", oeExp, parityOe);
    endtask : rd

    task automatic burst_wr(input logic [ADDR_W-1:0] s, input logic il);
        logic [ADDR_W-1:0] a;
        ssdc_host_model_i.step(1'b0, OP_WRITE, s, '0, '0, '1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            a = baddr(s, i, il);
            expMem[a] = {8'(a), {LANES{8'(a) ^ 8'hC3}}};
            ssdc_host_model_i.step(i < 3, i < 3 ? OP_WRITE : OP_DESEL, s,
                                   expMem[a][DATA_W-1:0], 8'(a), '0, 1'b1);
            #1;
            check_flag("burst write float", 1'b0, dataOe);
        end
        idle(1);
    endtask : burst_wr

    task automatic burst_rd(input logic [ADDR_W-1:0] s, input logic il);
        ssdc_host_model_i.step(1'b0, OP_READ, s, '0, '0, '1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            ssdc_host_model_i.step(i < 3, i < 3 ? OP_READ : OP_DESEL, s, '0, '0, '1, 1'b0);
            #1;
            check_word("burst beat", expMem[baddr(s, i, il)], {parityOut, dataOut});
            check_flag("burst drive", 1'b1, dataOe);
        end
        idle(1);
        #1;
        check_flag("deselect float", 1'b0, dataOe);
    endtask : burst_rd

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // ******************************************************************
    // tests
    // ******************************************************************
    initial begin
        logic [ADDR_W-1:0] s;
        {arst_n, outputEnableN, burstOrderStrap, burstOrderDriven} = 4'h3;
        {failures, checked} = '0;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        idle(2);
        wr(6'h05, {LANES{8'h3C}}, 8'hA5, 8'h00);
        rd(6'h05, 1'b1);
        wr(6'h05, {LANES{8'hE1}}, 8'h0F, 8'h5A);
        rd(6'h05, 1'b1);
        ssdc_host_model_i.step(1'b0, OP_READ, 6'h05, '0, '0, '1, 1'b0);
        ssdc_host_model_i.step(1'b0, OP_WRITE, 6'h05, '0, '0, '1, 1'b0);
        #1;
        check_flag("turnaround float", 1'b0, dataOe);
        ssdc_host_model_i.step(1'b0, OP_DESEL, 6'h05, '0, '0, '1, 1'b1);
        $display("test write and read done");
        @(negedge ref_clk);
        outputEnableN = 1'b1;
        idle(2);
        rd(6'h05, 1'b0);
        @(negedge ref_clk);
        outputEnableN = 1'b0;
        idle(2);
        $display("test output enable done");
        ssdc_host_model_i.step(1'b0, OP_READ, 6'h05, '0, '0, '1, 1'b0);
        ssdc_host_model_i.step(1'b0, OP_DESEL, 6'h05, '0, '0, '1, 1'b0);
        ssdc_host_model_i.freeze(4);
        #1;
        check_word("frozen word", expMem[6'h05], {parityOut, dataOut});
        check_flag("frozen drive", 1'b1, dataOe);
        idle(1);
        #1;
        check_flag("thawed float", 1'b0, dataOe);
        $display("test clock qualifier done");
        for (int m = 0; m < 3; m++) begin
            @(negedge ref_clk);
            burstOrderStrap = (m == 1);
            burstOrderDriven = (m != 2);
            idle(3);
            s = 6'(16 * m + 7);
            burst_wr(s, m != 0);
            for (int i = 0; i < 4; i++) rd({s[5:2], 2'(i)}, 1'b1);
            burst_rd(s, m != 0);
            $display("test burst mode %0d done", m);
        end
        check_flag("buffer ready", 1'b1, writeBufReady);
        finish_test();
    end

    initial begin
        #(2000 * 50);
        failures++;
        finish_test();
    end
endmodule : tb_top
